// ### reg_write_pkg.sv
package reg_write_pkg;

   // -------------------------------------------------------------------------
   // opcodes
   // -------------------------------------------------------------------------
   localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;  // register write
   localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;  // set write-enable latch
   localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;  // clear write-enable latch
   localparam logic [7:0] OP_CLEAR_STATUS   = 8'h30;  // clear error flags
   localparam logic [7:0] OP_BANK_ACCESS    = 8'hB9;  // open bank path

   // -------------------------------------------------------------------------
   // status register one field positions
   // -------------------------------------------------------------------------
   localparam int SR_WIP  = 0;  // write in progress
   localparam int SR_WEL  = 1;  // write-enable latch
   localparam int SR_BP0  = 2;  // block protect 0
   localparam int SR_BP2  = 4;  // block protect 2
   localparam int SR_EERR = 5;  // erase error
   localparam int SR_PERR = 6;  // program error
   localparam int SR_STATUS_WRITE_DISABLE = 7;  // status write disable
   localparam int CR_QUAD = 1;  // quad mode in configuration register

   // -------------------------------------------------------------------------
   // reset values and bit counts
   // -------------------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET = 8'h00;  // factory state
   localparam logic [7:0] CONFIG_RESET = 8'h00;  // configuration reset
   localparam logic [1:0] BANK_RESET   = 2'h0;   // bank bits reset
   localparam logic [5:0] BITS_OPCODE  = 6'h08;  // end of opcode
   localparam logic [5:0] BITS_ONE     = 6'h10;  // opcode plus one byte
   localparam logic [5:0] BITS_TWO     = 6'h18;  // opcode plus two bytes
   localparam logic [5:0] BITS_MAX     = 6'h3F;  // saturating count

   // self-timed update length, in cycles of clk
   localparam int WRITE_TIME_CYCLES = 16;

   // -------------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,  // nothing running
      ST_UPDATE = 2'b01,  // self-timed update running
      ST_FAILED = 2'b10   // update failed, busy until flags cleared
   } op_state_t;

   typedef struct packed {
      logic       cs_n;  // chip select, active low
      logic       sck;   // serial clock
      logic       si;    // serial input
      logic       wp_n;  // write protect, active low
   } pins_t;

   typedef struct packed {
      logic [7:0] status;  // status register one
      logic [7:0] cfg;     // configuration register
      logic [1:0] bank;    // bank bits 1:0
   } regs_t;

endpackage

// ### spi_flash_register_write_control.sv
// Functional notes
// - register write needs write-enable latch set
// - execute only after exactly eight/sixteen data bits
// - eight bits status only, sixteen adds configuration
// - valid write starts timed update, busy set
// - write-enable latch clears when update ends
// - failed update sets program or erase error
// - status write disable clear allows any pin level
// - disable set, pin high: writes allowed
// - disable set, pin low: writes rejected
// - protection holds until pin returns high
// - quad mode disables pin protection
// - status register resets to zero
// - write after bank access loads bank bits
// - write-enable command sets latch bit one
// - enable/disable only after exactly eight bits
// - write-disable command clears latch
// - write-disable ignored while busy
// - clear-status clears error flags, no latch needed
// - errors keep busy; clear accepted, latch kept
// - bank load uses low two bits, no latch
`timescale 1ns/1ns
module spi_flash_register_write_control #(
   parameter int WRITE_CYCLES = reg_write_pkg::WRITE_TIME_CYCLES  // update length
) (
   input  wire logic       clk,          // block clock, 25 MHz
   input  wire logic       rst_n,        // asynchronous reset, active low
   input  wire logic       clk_en,       // clock enable, freezes state when low
   input  wire logic       cs_n,         // chip select pin, active low
   input  wire logic       sck,          // serial clock pin
   input  wire logic       si,           // serial data in pin
   input  wire logic       wp_n,         // write protect pin, active low
   input  wire logic       fail_program, // update fails as program error
   input  wire logic       fail_erase,   // update fails as erase error
   output logic [7:0]      status_reg,   // status register one
   output logic [7:0]      config_reg,   // configuration register
   output logic [1:0]      bank_reg,     // bank address bits 1:0
   output logic            write_in_progress,  // busy flag
   output logic            write_enable_latch, // latch state
   output logic            hw_protected  // registers hardware protected
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   typedef struct packed {
      reg_write_pkg::pins_t     sync1;     // first synchroniser stage
      reg_write_pkg::pins_t     sync2;     // second synchroniser stage
      logic                     sck_prev;  // last synced clock level
      logic                     cs_prev;   // last synced select level
      logic [5:0]               bits;      // bits received this frame
      logic [7:0]               opcode;    // shifted opcode
      logic [15:0]              data;      // shifted data bytes
      logic                     bank_open; // previous frame was bank access
      reg_write_pkg::regs_t     regs;      // visible registers
      logic [7:0]               pend_sr;   // staged status value
      logic [7:0]               pend_cr;   // staged configuration value
      logic                     pend_two;  // configuration staged too
      logic                     pend_perr; // program failure latched at start
      logic                     pend_eerr; // erase failure latched at start
      logic [15:0]              timer;     // update cycles left
      reg_write_pkg::op_state_t op;        // operation state
   } state_t;

   state_t st_q;  // registered state
   state_t st_d;  // next state

   logic       sck_rise;   // rising serial clock edge
   logic       cs_fall;    // frame start
   logic       cs_rise;    // frame end
   logic       protect;    // registers frozen by pin
   logic       busy;       // write in progress
   logic [7:0] sr_new;     // status value to stage
   logic [7:0] cr_new;     // configuration value to stage

   // -------------------------------------------------------------------------
   // edge detection on second synchroniser stage
   // -------------------------------------------------------------------------
   assign sck_rise = st_q.sync2.sck & ~st_q.sck_prev;
   assign cs_fall  = ~st_q.sync2.cs_n & st_q.cs_prev;
   assign cs_rise  = st_q.sync2.cs_n & ~st_q.cs_prev;

   // protection whichever came last; released only by pin high, not in quad
   assign protect = st_q.regs.status[reg_write_pkg::SR_STATUS_WRITE_DISABLE] & ~st_q.sync2.wp_n
                    & ~st_q.regs.cfg[reg_write_pkg::CR_QUAD];
   // busy while updating or while an error flag stands
   assign busy = (st_q.op != reg_write_pkg::ST_IDLE)
                 | st_q.regs.status[reg_write_pkg::SR_PERR]
                 | st_q.regs.status[reg_write_pkg::SR_EERR];

   // -------------------------------------------------------------------------
   // staged values: latch and error flags kept from live register, busy bit set to one
   // -------------------------------------------------------------------------
   always_comb begin
      // eight-bit form carries status in data[7:0]; sixteen in data[15:8]
      if (st_q.bits == reg_write_pkg::BITS_TWO) begin
         sr_new = st_q.data[15:8];
         cr_new = st_q.data[7:0];
      end else begin
         sr_new = st_q.data[7:0];
         cr_new = st_q.regs.cfg;
      end
      // only protect, disable bits are software written
      sr_new[reg_write_pkg::SR_WIP]  = 1'b1;
      sr_new[reg_write_pkg::SR_WEL]  = st_q.regs.status[reg_write_pkg::SR_WEL];
      sr_new[reg_write_pkg::SR_EERR] = st_q.regs.status[reg_write_pkg::SR_EERR];
      sr_new[reg_write_pkg::SR_PERR] = st_q.regs.status[reg_write_pkg::SR_PERR];
   end

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.sync1    = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};
      st_d.sync2    = st_q.sync1;
      st_d.sck_prev = st_q.sync2.sck;
      st_d.cs_prev  = st_q.sync2.cs_n;

      // shift on rising clock inside a frame, msb first
      if (cs_fall) begin
         st_d.bits = 6'h00;
      end else if (sck_rise && !st_q.sync2.cs_n) begin
         if (st_q.bits < reg_write_pkg::BITS_OPCODE) begin
            st_d.opcode = {st_q.opcode[6:0], st_q.sync2.si};
         end else begin
            st_d.data = {st_q.data[14:0], st_q.sync2.si};
         end
         if (st_q.bits != reg_write_pkg::BITS_MAX) begin
            st_d.bits = st_q.bits + 6'h01;
         end
      end

      // timed update sequencing
      unique case (st_q.op)
         reg_write_pkg::ST_IDLE: begin
            // nothing running
         end
         reg_write_pkg::ST_UPDATE: begin
            if (st_q.timer == 16'h0001) begin
               st_d.regs.status[reg_write_pkg::SR_WEL] = 1'b0;
               if (st_q.pend_perr || st_q.pend_eerr) begin
                  st_d.op = reg_write_pkg::ST_FAILED;
                  if (st_q.pend_perr) begin
                     st_d.regs.status[reg_write_pkg::SR_PERR] = 1'b1;
                  end
                  if (st_q.pend_eerr) begin
                     st_d.regs.status[reg_write_pkg::SR_EERR] = 1'b1;
                  end
               end else begin
                  st_d.op = reg_write_pkg::ST_IDLE;
                  st_d.regs.status = st_q.pend_sr;
                  st_d.regs.status[reg_write_pkg::SR_WEL] = 1'b0;
                  if (st_q.pend_two) begin
                     st_d.regs.cfg = st_q.pend_cr;
                  end
               end
            end else begin
               st_d.timer = st_q.timer - 16'h0001;
            end
         end
         reg_write_pkg::ST_FAILED: begin
            if (!st_q.regs.status[reg_write_pkg::SR_PERR]
                && !st_q.regs.status[reg_write_pkg::SR_EERR]) begin
               st_d.op = reg_write_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d.op = reg_write_pkg::ST_IDLE;
         end
      endcase

      // frame end decoding
      if (cs_rise) begin
         st_d.bank_open = 1'b0;  // any frame closes the bank path
         if (st_q.opcode == reg_write_pkg::OP_REGISTER_WRITE && st_q.bank_open) begin
            // bank load: low two bits of first byte, no latch needed
            // a cut frame loads nothing, same as a plain register write
            if ((st_q.bits == reg_write_pkg::BITS_ONE || st_q.bits == reg_write_pkg::BITS_TWO)
                && !busy) begin
               st_d.regs.bank = (st_q.bits == reg_write_pkg::BITS_TWO)
                                ? st_q.data[9:8] : st_q.data[1:0];
            end
         end else if (st_q.opcode == reg_write_pkg::OP_REGISTER_WRITE) begin
            if ((st_q.bits == reg_write_pkg::BITS_ONE
                 || st_q.bits == reg_write_pkg::BITS_TWO)
                && st_q.regs.status[reg_write_pkg::SR_WEL]
                && !protect && !busy) begin
               st_d.op       = reg_write_pkg::ST_UPDATE;
               st_d.timer    = 16'(WRITE_CYCLES);
               st_d.pend_sr  = sr_new;
               st_d.pend_cr  = cr_new;
               st_d.pend_two = (st_q.bits == reg_write_pkg::BITS_TWO);
               st_d.pend_perr = fail_program;
               st_d.pend_eerr = fail_erase & ~fail_program;
            end
         end else if (st_q.bits == reg_write_pkg::BITS_OPCODE) begin
            if (st_q.opcode == reg_write_pkg::OP_WRITE_ENABLE && !busy) begin
               st_d.regs.status[reg_write_pkg::SR_WEL] = 1'b1;
            end else if (st_q.opcode == reg_write_pkg::OP_WRITE_DISABLE && !busy) begin
               st_d.regs.status[reg_write_pkg::SR_WEL] = 1'b0;
            end else if (st_q.opcode == reg_write_pkg::OP_CLEAR_STATUS
                         && st_q.op != reg_write_pkg::ST_UPDATE) begin
               st_d.regs.status[reg_write_pkg::SR_PERR] = 1'b0;
               st_d.regs.status[reg_write_pkg::SR_EERR] = 1'b0;
            end else if (st_q.opcode == reg_write_pkg::OP_BANK_ACCESS) begin
               st_d.bank_open = 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.sync1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         st_q.sync2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         st_q.cs_prev <= 1'b1;
         st_q.regs <= '{status: reg_write_pkg::STATUS_RESET,
                        cfg:    reg_write_pkg::CONFIG_RESET,
                        bank:   reg_write_pkg::BANK_RESET};
         st_q.op <= reg_write_pkg::ST_IDLE;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   always_comb begin
      status_reg = st_q.regs.status;
      status_reg[reg_write_pkg::SR_WIP] = busy;
   end
   assign config_reg         = st_q.regs.cfg;
   assign bank_reg           = st_q.regs.bank;
   assign write_in_progress  = busy;
   assign write_enable_latch = st_q.regs.status[reg_write_pkg::SR_WEL];
   assign hw_protected       = protect;

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_update_sets_busy: assert property (st_q.op == reg_write_pkg::ST_UPDATE |-> busy)
      else $error("busy low during update");
   a_latch_clear_end: assert property (clk_en && st_q.op == reg_write_pkg::ST_UPDATE
      && st_q.timer == 16'h0001 |=> !write_enable_latch)
      else $error("latch not cleared at update end");
   a_no_write_unlatched: assert property (clk_en && $rose(st_q.op == reg_write_pkg::ST_UPDATE)
      |-> $past(write_enable_latch))
      else $error("update started without latch");
   a_protect_blocks: assert property (clk_en && protect
      && st_q.op == reg_write_pkg::ST_IDLE |=> st_q.op != reg_write_pkg::ST_UPDATE)
      else $error("write accepted while protected");
   a_quad_no_protect: assert property (config_reg[reg_write_pkg::CR_QUAD] |-> !hw_protected)
      else $error("pin protection active in quad mode");
   a_error_keeps_busy: assert property (status_reg[reg_write_pkg::SR_PERR]
      || status_reg[reg_write_pkg::SR_EERR] |-> write_in_progress)
      else $error("error flag without busy");
   a_disable_ignored: assert property (busy && clk_en && cs_rise
      && st_q.opcode == reg_write_pkg::OP_WRITE_DISABLE && st_q.op == reg_write_pkg::ST_UPDATE
      && st_q.timer != 16'h0001
      |=> write_enable_latch == $past(write_enable_latch))
      else $error("write disable acted while busy");
   a_enable_sets: assert property (clk_en && cs_rise && !busy
      && st_q.opcode == reg_write_pkg::OP_WRITE_ENABLE
      && st_q.bits == reg_write_pkg::BITS_OPCODE |=> write_enable_latch)
      else $error("write enable did not set latch");
   a_count_refused: assert property (clk_en && cs_rise
      && st_q.opcode == reg_write_pkg::OP_REGISTER_WRITE && st_q.op == reg_write_pkg::ST_IDLE
      && st_q.bits != reg_write_pkg::BITS_ONE && st_q.bits != reg_write_pkg::BITS_TWO
      |=> st_q.op == reg_write_pkg::ST_IDLE)
      else $error("register write with wrong bit count accepted");
   a_fail_sets_flag: assert property (clk_en && st_q.op == reg_write_pkg::ST_UPDATE
      && st_q.timer == 16'h0001 && (st_q.pend_perr || st_q.pend_eerr)
      |=> status_reg[reg_write_pkg::SR_PERR] || status_reg[reg_write_pkg::SR_EERR])
      else $error("failed update left no error flag");
   a_busy_drops: assert property (clk_en && st_q.op == reg_write_pkg::ST_UPDATE
      && st_q.timer == 16'h0001 && !st_q.pend_perr && !st_q.pend_eerr
      |=> !write_in_progress)
      else $error("busy kept after clean update");
   a_clear_keeps_latch: assert property (clk_en && cs_rise
      && st_q.opcode == reg_write_pkg::OP_CLEAR_STATUS && st_q.op != reg_write_pkg::ST_UPDATE
      |=> write_enable_latch == $past(write_enable_latch))
      else $error("clear status changed latch");
   a_bank_no_update: assert property (clk_en && cs_rise && st_q.bank_open
      && st_q.opcode == reg_write_pkg::OP_REGISTER_WRITE && st_q.op == reg_write_pkg::ST_IDLE
      |=> st_q.op == reg_write_pkg::ST_IDLE)
      else $error("bank load started a register update");

   c_update_run:   cover property (st_q.op == reg_write_pkg::ST_UPDATE ##1 st_q.op == reg_write_pkg::ST_IDLE);
   c_failed:       cover property (st_q.op == reg_write_pkg::ST_FAILED);
   c_protected:    cover property (hw_protected);
   c_bank_loaded:  cover property ($changed(bank_reg));

endmodule

// ### spi_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// host side of the serial link
// ----------------------------------------------------------------------------
module spi_host_model (
   input  wire logic clk,   // block clock, paces the link
   output logic      cs_n,  // chip select, active low
   output logic      sck,   // serial clock, still outside frames
   output logic      si     // serial data to the device
);
   // idle link at time zero
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end

   // half of the 320 ns link period
   task automatic half_bit();
      repeat (4) @(negedge clk);
   endtask

   // frame: opcode in bits 23:16, then data bytes, n bits sent
   task automatic send(input logic [23:0] bits, input int n);
      int i;
      @(negedge clk);
      cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         si = bits[23 - i];  // msb first
         half_bit();
         sck = 1'b1;  // device samples on this rise
         half_bit();
         sck = 1'b0;
      end
      half_bit();
      cs_n = 1'b1;  // raised half a bit period after the last clock fall
      si   = ~si;   // released line shows no stale value
      repeat (6) @(negedge clk);
   endtask
endmodule

// ### spi_flash_register_write_control_bench.sv
`timescale 1ns/1ns
module spi_flash_register_write_control_bench;
   // -------------------------------------------------------------------------
   // signals
   // -------------------------------------------------------------------------
   logic       clk;            // block clock
   logic       rst_n;          // reset, active low
   logic       clk_en;         // clock enable
   logic       cs_n;           // link chip select
   logic       sck;            // link clock
   logic       si;             // link data
   logic       wp_n;           // write protect pin
   logic       fail_program;   // inject program failure
   logic       fail_erase;     // inject erase failure
   logic [7:0] status_reg;     // status register one
   logic [7:0] config_reg;     // configuration register
   logic [1:0] bank_reg;       // bank bits
   logic       write_in_progress;  // busy
   logic       write_enable_latch; // latch
   logic       hw_protected;   // hardware protection
   int         failures;       // mismatches
   int         tests_run;      // comparisons
   int         cycles;         // timeout counter

   spi_host_model u_spi_host_model (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));

   spi_flash_register_write_control #(.WRITE_CYCLES(120)) u_spi_flash_register_write_control (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n), .sck(sck), .si(si),
      .wp_n(wp_n), .fail_program(fail_program), .fail_erase(fail_erase),
      .status_reg(status_reg), .config_reg(config_reg), .bank_reg(bank_reg),
      .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
      .hw_protected(hw_protected));

   // -------------------------------------------------------------------------
   // clock and timeout
   // -------------------------------------------------------------------------
   initial clk = 1'b0;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   // -------------------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------------------
   task automatic print_verdict();
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // compare and count
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   // wait for busy to drop, bounded
   task automatic wait_idle();
      int i;
      for (i = 0; i < 200 && write_in_progress !== 1'b0; i++) @(negedge clk);
      chk("busy", 8'h00, {7'h00, write_in_progress});
   endtask

   // register write after setting the latch
   task automatic wr(input logic [23:0] bits, input int n);
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_ENABLE, 16'h0000}, 8);
      u_spi_host_model.send(bits, n);
   endtask

   // -------------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------------
   task automatic t_latch();
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_ENABLE, 16'h0000}, 8);
      chk("latch set", 8'h01, {7'h00, write_enable_latch});
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_DISABLE, 16'h0000}, 9);
      chk("latch kept", 8'h01, {7'h00, write_enable_latch});
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_DISABLE, 16'h0000}, 8);
      chk("latch clear", 8'h00, {7'h00, write_enable_latch});
      u_spi_host_model.send({reg_write_pkg::OP_REGISTER_WRITE, 8'h1C, 8'h00}, 16);
      repeat (30) @(negedge clk);
      chk("no latch", 8'h00, status_reg);
   endtask

   task automatic t_write8();
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h9F, 8'h00}, 16);
      chk("busy on", 8'h01, {7'h00, write_in_progress});
      clk_en = 1'b0;
      repeat (200) @(negedge clk);
      chk("frozen busy", 8'h01, {7'h00, write_in_progress});
      clk_en = 1'b1;
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_DISABLE, 16'h0000}, 8);
      chk("busy latch", 8'h01, {7'h00, write_enable_latch});
      wait_idle();
      chk("status8", 8'h9C, status_reg);
      chk("latch end", 8'h00, {7'h00, write_enable_latch});
      chk("config8", 8'h00, config_reg);
   endtask

   task automatic t_protect();
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h80, 8'h02}, 24);
      wait_idle();
      chk("status16", 8'h80, status_reg);
      chk("config16", 8'h02, config_reg);
      wp_n = 1'b0;
      repeat (6) @(negedge clk);
      chk("quad unprot", 8'h00, {7'h00, hw_protected});
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h80, 8'h00}, 24);
      wait_idle();
      chk("quad write", 8'h00, config_reg);
      chk("protected", 8'h01, {7'h00, hw_protected});
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h00, 8'h02}, 24);
      repeat (30) @(negedge clk);
      chk("frozen", 8'h82, status_reg);
      chk("frozen cfg", 8'h00, config_reg);
      wp_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("released", 8'h00, {7'h00, hw_protected});
      u_spi_host_model.send({reg_write_pkg::OP_REGISTER_WRITE, 16'h0000}, 24);
      wait_idle();
      chk("pin high", 8'h00, status_reg);
      wp_n = 1'b0;
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h0C, 8'h00}, 16);
      wait_idle();
      chk("status_write_disable clear", 8'h0C, status_reg);
      wp_n = 1'b1;
   endtask

   task automatic t_count();
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h04, 8'h00}, 20);
      repeat (30) @(negedge clk);
      chk("bad count", 8'h0E, status_reg);
      u_spi_host_model.send({reg_write_pkg::OP_WRITE_DISABLE, 16'h0000}, 8);
   endtask

   task automatic t_fail();
      fail_program = 1'b1;
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h00, 8'h00}, 16);
      fail_program = 1'b0;
      repeat (130) @(negedge clk);
      chk("prog err", 8'h4D, status_reg);
      u_spi_host_model.send({reg_write_pkg::OP_CLEAR_STATUS, 16'h0000}, 8);
      chk("cleared", 8'h0C, status_reg);
      fail_erase = 1'b1;
      wr({reg_write_pkg::OP_REGISTER_WRITE, 8'h00, 8'h00}, 16);
      fail_erase = 1'b0;
      repeat (130) @(negedge clk);
      chk("erase err", 8'h2D, status_reg);
      u_spi_host_model.send({reg_write_pkg::OP_CLEAR_STATUS, 16'h0000}, 8);
      chk("cleared2", 8'h0C, status_reg);
   endtask

   task automatic t_bank();
      u_spi_host_model.send({reg_write_pkg::OP_BANK_ACCESS, 16'h0000}, 8);
      u_spi_host_model.send({reg_write_pkg::OP_REGISTER_WRITE, 8'hFE, 8'h00}, 16);
      repeat (30) @(negedge clk);
      chk("bank", 8'h02, {6'h00, bank_reg});
      chk("bank status", 8'h0C, status_reg);
      u_spi_host_model.send({reg_write_pkg::OP_REGISTER_WRITE, 8'hFD, 8'h00}, 16);
      repeat (30) @(negedge clk);
      chk("path closed", 8'h02, {6'h00, bank_reg});
   endtask

   // -------------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      wp_n = 1'b1;
      fail_program = 1'b0;
      fail_erase = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset status", reg_write_pkg::STATUS_RESET, status_reg);
      t_latch();
      t_write8();
      t_protect();
      t_count();
      t_fail();
      t_bank();
      print_verdict();
   end
endmodule
